// >>> verilog/subframe_timing_pkg.sv
// Register map, reset values and field layout of the sub-frame timing window generator
package subframe_timing_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int PADDR_W = 10;
  localparam int POS_W = 16;
  localparam int IDX_W = 8;
  localparam int NUM_WIN = 4;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CONTROL = 8'h80;
  localparam logic [7:0] IDX_SEQ_IRQ_START = 8'h85;
  localparam logic [7:0] IDX_SEQ_IRQ_END = 8'h86;
  localparam logic [7:0] IDX_CAPTURE_START = 8'h87;
  localparam logic [7:0] IDX_CAPTURE_END = 8'h88;
  localparam logic [7:0] IDX_OVERLOAD_START = 8'h89;
  localparam logic [7:0] IDX_OVERLOAD_END = 8'h8a;
  localparam logic [7:0] IDX_ILLUM_START = 8'h8f;
  localparam logic [7:0] IDX_ILLUM_END = 8'h90;
  localparam logic [7:0] IDX_STATUS = 8'h9f;

  // ==========================================================================
  // Reset values (also the automatic defaults of the capture and overload windows)
  localparam logic [15:0] SEQ_IRQ_START_RST = 16'h0020;
  localparam logic [15:0] SEQ_IRQ_END_RST = 16'h0028;
  localparam logic [15:0] CAPTURE_START_RST = 16'h2454;
  localparam logic [15:0] CAPTURE_END_RST = 16'h2648;
  localparam logic [15:0] OVERLOAD_START_RST = 16'h03e8;
  localparam logic [15:0] OVERLOAD_END_RST = 16'h1f40;
  localparam logic [15:0] ILLUM_START_RST = 16'h0000;
  localparam logic [15:0] ILLUM_END_RST = 16'h2134;
  localparam logic [15:0] SUBFRAME_LENGTH_RST = 16'h270f;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LENGTH_LSB = 1;
  localparam int CTRL_AUTO_DIS_BIT = 23;

  // ==========================================================================
  // Status register fields
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_STROBE_LSB = 16;

  // ==========================================================================
  // Strobe slots
  localparam int WIN_SEQ_IRQ = 0;
  localparam int WIN_CAPTURE = 1;
  localparam int WIN_OVERLOAD = 2;
  localparam int WIN_ILLUM = 3;

endpackage

// >>> verilog/window_strobe.sv
// One registered strobe that is high while a count lies inside a start/end window
`timescale 1ns/1ps
`default_nettype none
module window_strobe (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic [15:0] count,
  input wire logic [15:0] start_pos,
  input wire logic [15:0] end_pos,
  output logic strobe_r
);

  typedef struct packed {
    logic strobe;
  } win_state_t;

  win_state_t st_r;
  win_state_t st_nxt;

  // ==========================================================================
  // Window compare: at or above start, below end
  always_comb begin
    st_nxt = st_r;
    st_nxt.strobe = active && (count >= start_pos) && (count < end_pos);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign strobe_r = st_r.strobe;

endmodule
`default_nettype wire

// >>> verilog/subframe_timing_window_generator.sv
// Sub-frame counter with programmable strobe windows, registers on APB
`timescale 1ns/1ps
`default_nettype none
module subframe_timing_window_generator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [subframe_timing_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic seq_irq_strobe,
  output logic capture_strobe,
  output logic overload_window,
  output logic illum_enable
);

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] seq_start;
    logic [15:0] seq_end;
    logic [15:0] cap_start;
    logic [15:0] cap_end;
    logic [15:0] ovl_start;
    logic [15:0] ovl_end;
    logic [15:0] illum_start;
    logic [15:0] illum_end;
    logic [15:0] length;
    logic enable;
    logic auto_dis;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gen_state_t;

  gen_state_t st_r;
  gen_state_t st_nxt;

  logic [subframe_timing_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic hit;
  logic access;
  logic commit;
  logic pos_read;
  logic [15:0] cap_s_eff;
  logic [15:0] cap_e_eff;
  logic [15:0] ovl_s_eff;
  logic [15:0] ovl_e_eff;
  logic [subframe_timing_pkg::NUM_WIN-1:0][15:0] win_start;
  logic [subframe_timing_pkg::NUM_WIN-1:0][15:0] win_end;
  logic [subframe_timing_pkg::NUM_WIN-1:0] strobes;

  // ==========================================================================
  // Helpers

  // Index names a mapped register
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      subframe_timing_pkg::IDX_CONTROL, subframe_timing_pkg::IDX_SEQ_IRQ_START,
      subframe_timing_pkg::IDX_SEQ_IRQ_END, subframe_timing_pkg::IDX_CAPTURE_START,
      subframe_timing_pkg::IDX_CAPTURE_END, subframe_timing_pkg::IDX_OVERLOAD_START,
      subframe_timing_pkg::IDX_OVERLOAD_END, subframe_timing_pkg::IDX_ILLUM_START,
      subframe_timing_pkg::IDX_ILLUM_END, subframe_timing_pkg::IDX_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Index names one of the 16-bit position registers
  function automatic logic is_position(input logic [7:0] i);
    is_position = is_mapped(i) && (i != subframe_timing_pkg::IDX_CONTROL) &&
                  (i != subframe_timing_pkg::IDX_STATUS);
  endfunction

  // Position value placed in the low half, upper bits zero
  function automatic logic [31:0] pos_word(input logic [15:0] v);
    pos_word = {16'h0000, v};
  endfunction

  // Last count of the sub-frame; a zero length acts as one clock
  function automatic logic is_last(input logic [15:0] cnt, input logic [15:0] len);
    is_last = (len == 16'h0000) || (cnt >= len - 16'h0001);
  endfunction

  // ==========================================================================
  // Effective positions: automatic defaults unless overridden
  always_comb begin
    if (st_r.auto_dis) begin
      cap_s_eff = st_r.cap_start;
      cap_e_eff = st_r.cap_end;
      ovl_s_eff = st_r.ovl_start;
      ovl_e_eff = st_r.ovl_end;
    end else begin
      cap_s_eff = subframe_timing_pkg::CAPTURE_START_RST;
      cap_e_eff = subframe_timing_pkg::CAPTURE_END_RST;
      ovl_s_eff = subframe_timing_pkg::OVERLOAD_START_RST;
      ovl_e_eff = subframe_timing_pkg::OVERLOAD_END_RST;
    end
  end

  // Window table for the strobe instances
  always_comb begin
    win_start[subframe_timing_pkg::WIN_SEQ_IRQ] = st_r.seq_start;
    win_end[subframe_timing_pkg::WIN_SEQ_IRQ] = st_r.seq_end;
    win_start[subframe_timing_pkg::WIN_CAPTURE] = cap_s_eff;
    win_end[subframe_timing_pkg::WIN_CAPTURE] = cap_e_eff;
    win_start[subframe_timing_pkg::WIN_OVERLOAD] = ovl_s_eff;
    win_end[subframe_timing_pkg::WIN_OVERLOAD] = ovl_e_eff;
    win_start[subframe_timing_pkg::WIN_ILLUM] = st_r.illum_start;
    win_end[subframe_timing_pkg::WIN_ILLUM] = st_r.illum_end;
  end

  // ==========================================================================
  // APB decode
  assign idx = paddr[subframe_timing_pkg::PADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit = aligned && is_mapped(idx);
  assign access = psel && penable && !st_r.pready;
  assign commit = psel && penable && st_r.pready && pwrite && hit; // Completing edge of a write
  assign pos_read = access && !pwrite && aligned && is_position(idx);

  // ==========================================================================
  // Next state: bus slave, register file and sub-frame counter
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (access) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      if (!pwrite) begin
        case (hit ? idx : 8'h00)
          subframe_timing_pkg::IDX_CONTROL: st_nxt.prdata = {8'h00, st_r.auto_dis, 6'h00, st_r.length, st_r.enable};
          subframe_timing_pkg::IDX_SEQ_IRQ_START: st_nxt.prdata = pos_word(st_r.seq_start);
          subframe_timing_pkg::IDX_SEQ_IRQ_END: st_nxt.prdata = pos_word(st_r.seq_end);
          subframe_timing_pkg::IDX_CAPTURE_START: st_nxt.prdata = pos_word(st_r.cap_start);
          subframe_timing_pkg::IDX_CAPTURE_END: st_nxt.prdata = pos_word(st_r.cap_end);
          subframe_timing_pkg::IDX_OVERLOAD_START: st_nxt.prdata = pos_word(st_r.ovl_start);
          subframe_timing_pkg::IDX_OVERLOAD_END: st_nxt.prdata = pos_word(st_r.ovl_end);
          subframe_timing_pkg::IDX_ILLUM_START: st_nxt.prdata = pos_word(st_r.illum_start);
          subframe_timing_pkg::IDX_ILLUM_END: st_nxt.prdata = pos_word(st_r.illum_end);
          subframe_timing_pkg::IDX_STATUS: st_nxt.prdata = {12'h000, strobes, st_r.count};
          default: st_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end
    // Writes land only at the edge where the master sees pready high
    if (commit) begin
      // Bits 31:16 of position writes are dropped
      case (idx)
        subframe_timing_pkg::IDX_CONTROL: begin
          st_nxt.enable = pwdata[subframe_timing_pkg::CTRL_ENABLE_BIT];
          st_nxt.length = pwdata[subframe_timing_pkg::CTRL_LENGTH_LSB +: 16];
          st_nxt.auto_dis = pwdata[subframe_timing_pkg::CTRL_AUTO_DIS_BIT];
        end
        subframe_timing_pkg::IDX_SEQ_IRQ_START: st_nxt.seq_start = pwdata[15:0];
        subframe_timing_pkg::IDX_SEQ_IRQ_END: st_nxt.seq_end = pwdata[15:0];
        subframe_timing_pkg::IDX_CAPTURE_START: st_nxt.cap_start = pwdata[15:0];
        subframe_timing_pkg::IDX_CAPTURE_END: st_nxt.cap_end = pwdata[15:0];
        subframe_timing_pkg::IDX_OVERLOAD_START: st_nxt.ovl_start = pwdata[15:0];
        subframe_timing_pkg::IDX_OVERLOAD_END: st_nxt.ovl_end = pwdata[15:0];
        subframe_timing_pkg::IDX_ILLUM_START: st_nxt.illum_start = pwdata[15:0];
        subframe_timing_pkg::IDX_ILLUM_END: st_nxt.illum_end = pwdata[15:0];
        default: st_nxt.length = st_r.length;
      endcase
    end
    // Sub-frame counter, held at zero while disabled
    if (!st_r.enable) begin
      st_nxt.count = 16'h0000;
    end else if (is_last(st_r.count, st_r.length)) begin
      st_nxt.count = 16'h0000;
    end else begin
      st_nxt.count = st_r.count + 16'h0001;
    end
  end

  // State register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.count <= 16'h0000;
      st_r.seq_start <= subframe_timing_pkg::SEQ_IRQ_START_RST;
      st_r.seq_end <= subframe_timing_pkg::SEQ_IRQ_END_RST;
      st_r.cap_start <= subframe_timing_pkg::CAPTURE_START_RST;
      st_r.cap_end <= subframe_timing_pkg::CAPTURE_END_RST;
      st_r.ovl_start <= subframe_timing_pkg::OVERLOAD_START_RST;
      st_r.ovl_end <= subframe_timing_pkg::OVERLOAD_END_RST;
      st_r.illum_start <= subframe_timing_pkg::ILLUM_START_RST;
      st_r.illum_end <= subframe_timing_pkg::ILLUM_END_RST;
      st_r.length <= subframe_timing_pkg::SUBFRAME_LENGTH_RST;
      st_r.enable <= 1'b0;
      st_r.auto_dis <= 1'b0;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Strobe generators, gated by the unit enable
  genvar w;
  generate
    for (w = 0; w < subframe_timing_pkg::NUM_WIN; w++) begin : g_win
      window_strobe u_win (
        .pclk(pclk),
        .presetn(presetn),
        .active(st_r.enable),
        .count(st_r.count),
        .start_pos(win_start[w]),
        .end_pos(win_end[w]),
        .strobe_r(strobes[w])
      );
    end
  endgenerate

  // Outputs
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign seq_irq_strobe = strobes[subframe_timing_pkg::WIN_SEQ_IRQ];
  assign capture_strobe = strobes[subframe_timing_pkg::WIN_CAPTURE];
  assign overload_window = strobes[subframe_timing_pkg::WIN_OVERLOAD];
  assign illum_enable = strobes[subframe_timing_pkg::WIN_ILLUM];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SEQ_START: assert property (
    (st_r.enable && st_r.count == st_r.seq_start && st_r.seq_start < st_r.seq_end) |=> seq_irq_strobe)
    else $error("sequencer strobe missed its start");

  AST_SEQ_END: assert property (
    (st_r.enable && st_r.count == st_r.seq_end) |=> !seq_irq_strobe)
    else $error("sequencer strobe passed its end");

  AST_CAP_START: assert property (
    (st_r.enable && st_r.count == cap_s_eff && cap_s_eff < cap_e_eff) |=> capture_strobe)
    else $error("capture strobe missed its start");

  AST_CAP_END: assert property (
    (st_r.enable && st_r.count == cap_e_eff) |=> !capture_strobe)
    else $error("capture strobe passed its end");

  AST_OVL_START: assert property (
    (st_r.enable && st_r.count == ovl_s_eff && ovl_s_eff < ovl_e_eff) |=> overload_window)
    else $error("overload window missed its start");

  AST_OVL_END: assert property (
    (st_r.enable && st_r.count == ovl_e_eff) |=> !overload_window)
    else $error("overload window passed its end");

  AST_ILLUM_START: assert property (
    (st_r.enable && st_r.count == st_r.illum_start && st_r.illum_start < st_r.illum_end) |=> illum_enable)
    else $error("illumination enable missed its start");

  AST_ILLUM_END: assert property (
    (st_r.enable && st_r.count == st_r.illum_end) |=> !illum_enable)
    else $error("illumination enable passed its end");

  AST_RSVD_ZERO: assert property (
    $past(pos_read) |-> (pready && prdata[31:16] == 16'h0000))
    else $error("position read shows upper bits set");

  AST_WRAP: assert property (
    (st_r.enable && st_r.length != 16'h0000 && st_r.count == st_r.length - 16'h0001) |=> st_r.count == 16'h0000)
    else $error("sub-frame counter did not wrap at length");

  AST_DISABLED: assert property (
    !st_r.enable |=> (st_r.count == 16'h0000 && strobes == 4'h0))
    else $error("strobe or count active while disabled");

  AST_AUTO_CFG: assert property (
    !st_r.auto_dis |-> (cap_s_eff == subframe_timing_pkg::CAPTURE_START_RST &&
                        ovl_e_eff == subframe_timing_pkg::OVERLOAD_END_RST))
    else $error("automatic defaults not applied");

  AST_STEP: assert property (
    (st_r.enable && !is_last(st_r.count, st_r.length)) ##1 st_r.enable |-> st_r.count == $past(st_r.count) + 16'h0001)
    else $error("sub-frame counter skipped a count");

  CVR_WRAP: cover property (st_r.enable && st_r.count == 16'h0000 && $past(st_r.count) != 16'h0000);
  CVR_CAPTURE: cover property ($rose(capture_strobe));
  CVR_WRITE: cover property (pready && !pslverr && $past(pwrite));
  CVR_OVERRIDE: cover property (st_r.auto_dis && overload_window);

endmodule
`default_nettype wire

// >>> test/strobe_sink_model.sv
// Far-side model: front-end and illumination driver timing the four strobes it receives
`timescale 1ns/1ps
`default_nettype none
module strobe_sink_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] strobe,
  output var logic [31:0] rise_t [4],
  output var logic [31:0] width [4],
  output var logic [31:0] period [4],
  output var logic [31:0] nrise [4]
);
  logic [31:0] cyc_r;
  logic [3:0] prev_r;

  // ==========================================================================
  // Edge stamps
  // Stamp every rise and fall against a free cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= '0;
      prev_r <= '0;
      for (int k = 0; k < 4; k++) begin
        rise_t[k] <= '0;
        width[k] <= '0;
        period[k] <= '0;
        nrise[k] <= '0;
      end
    end else begin
      cyc_r <= cyc_r + 32'h1;
      prev_r <= strobe;
      for (int k = 0; k < 4; k++) begin
        if (strobe[k] && !prev_r[k]) begin
          rise_t[k] <= cyc_r;
          period[k] <= cyc_r - rise_t[k]; // Rise to rise
          nrise[k] <= nrise[k] + 32'h1;
        end
        if (!strobe[k] && prev_r[k]) begin
          width[k] <= cyc_r - rise_t[k]; // Cycles held high
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the sub-frame timing window generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic seq_irq_strobe;
  logic capture_strobe;
  logic overload_window;
  logic illum_enable;
  logic [3:0] strobe;
  logic [31:0] rise_t [4];
  logic [31:0] width [4];
  logic [31:0] period [4];
  logic [31:0] nrise [4];
  logic [31:0] snap [4];
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] idx_tab [8] = '{8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8f, 8'h90};
  logic [15:0] rst_tab [8] = '{16'h0020, 16'h0028, 16'h2454, 16'h2648, 16'h03e8, 16'h1f40, 16'h0000, 16'h2134};

  // ==========================================================================
  // Clock and instances
  always #50 pclk = ~pclk;
  assign strobe = {illum_enable, overload_window, capture_strobe, seq_irq_strobe};

  subframe_timing_window_generator i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seq_irq_strobe(seq_irq_strobe), .capture_strobe(capture_strobe),
    .overload_window(overload_window), .illum_enable(illum_enable)
  );

  strobe_sink_model i_sink (
    .pclk(pclk), .presetn(presetn), .strobe(strobe),
    .rise_t(rise_t), .width(width), .period(period), .nrise(nrise)
  );

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, {31'h0, experr});
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] v;
    logic err;
    apb(1'b0, a, 32'h0, v, err);
    chk({31'h0, err}, {31'h0, experr});
    chk(v, exp);
  endtask

  // Wait, bounded, for n more rises of strobe k
  task automatic wait_rise(input int k, input int n);
    logic [31:0] base;
    int c;
    base = nrise[k];
    c = 0;
    while (nrise[k] !== base + n && c < 30000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 30000) error_cnt++;
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    results();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd({idx_tab[i], 2'b00}, {16'h0, rst_tab[i]}, 1'b0);
    end
    rd({8'h80, 2'b00}, 32'h00004e1e, 1'b0);
    $display("test reset_values done");

    // Default windows over a full sub-frame
    wr({8'h80, 2'b00}, 32'h00004e1f, 1'b0);
    wait_rise(0, 2);
    chk(width[0], 32'h8);
    chk(width[1], 32'h1f4);
    chk(width[2], 32'h1b58);
    chk(width[3], 32'h2134);
    chk(period[0], 32'h270f);
    chk(rise_t[0] - rise_t[3], 32'h20);
    $display("test default_windows done");

    // Register writes, reserved bits, unmapped and misaligned access
    wr({8'h80, 2'b00}, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr({idx_tab[i], 2'b00}, 32'h1000 + i * 32'h111, 1'b0);
      rd({idx_tab[i], 2'b00}, 32'h1000 + i * 32'h111, 1'b0);
    end
    wr({8'h85, 2'b00}, 32'hff005a5a, 1'b0);
    rd({8'h85, 2'b00}, 32'h00005a5a, 1'b0);
    rd({8'h81, 2'b00}, 32'h0, 1'b1);
    wr({8'h8b, 2'b00}, 32'h1, 1'b1);
    rd({8'h85, 2'b01}, 32'h0, 1'b1);
    $display("test register_access done");

    // Short sub-frame with user windows
    wr({8'h85, 2'b00}, 32'd5, 1'b0);
    wr({8'h86, 2'b00}, 32'd9, 1'b0);
    wr({8'h87, 2'b00}, 32'd20, 1'b0);
    wr({8'h88, 2'b00}, 32'd40, 1'b0);
    wr({8'h89, 2'b00}, 32'd50, 1'b0);
    wr({8'h8a, 2'b00}, 32'd60, 1'b0);
    wr({8'h8f, 2'b00}, 32'd10, 1'b0);
    wr({8'h90, 2'b00}, 32'd30, 1'b0);
    wr({8'h80, 2'b00}, 32'h008000c9, 1'b0);
    wait_rise(2, 2);
    chk(width[0], 32'd4);
    chk(width[1], 32'd20);
    chk(width[2], 32'd10);
    chk(width[3], 32'd20);
    for (int k = 0; k < 4; k++) begin
      chk(period[k], 32'd100);
    end
    chk(rise_t[1] - rise_t[0], 32'd15);
    chk(rise_t[2] - rise_t[0], 32'd45);
    chk(rise_t[3] - rise_t[0], 32'd5);
    $display("test user_windows done");

    // Automatic defaults back: capture and overload stay out of a short sub-frame
    wr({8'h80, 2'b00}, 32'h000000c9, 1'b0);
    snap = nrise;
    wait_rise(0, 2);
    chk(nrise[1], snap[1]);
    chk(nrise[2], snap[2]);
    chk(width[0], 32'd4);
    rd({8'h87, 2'b00}, 32'd20, 1'b0);
    $display("test auto_defaults done");

    // Unit disabled: no strobe rises
    wr({8'h80, 2'b00}, 32'h000000c8, 1'b0);
    snap = nrise;
    repeat (300) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      chk(nrise[k], snap[k]);
    end
    chk({28'h0, strobe}, 32'h0);
    wr({8'h9f, 2'b00}, 32'h0000ffff, 1'b0);
    rd({8'h9f, 2'b00}, 32'h0, 1'b0);
    $display("test disable done");
    results();
  end
endmodule
`default_nettype wire
